/* verilog/gpio_pkg.sv */
// shared constants for the general purpose pin port
package gpio_pkg;

	// ==========================================================
	// widths and reset values
	localparam int         PIN_COUNT   = 11;                  // pins in the port
	localparam logic [10:0] CFG_RESET  = 11'h000;             // select/direction after reset
	localparam logic [10:0] DATA_RESET = 11'h000;             // data bits after reset
	localparam logic [10:0] LEVEL_IDLE = 11'h000;             // sampled level before first pass
	localparam logic [3:0]  DS_RESET_IDLE = 4'hf;             // reset outputs inactive (high)
	localparam logic [2:0]  IRQ_IDLE   = 3'h7;                // expander interrupts inactive

	// ==========================================================
	// input sampling time
	localparam int CLK_PERIOD_NS    = 20;                      // core clock period
	localparam int SAMPLE_PERIOD_NS = 128;                     // least time between samples
	localparam int SAMPLE_CYCLES    =
		(SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS; // rounded up
	localparam int SAMPLE_CNT_W     = 3;                       // counter width
	localparam logic [2:0] SAMPLE_LAST = 3'(SAMPLE_CYCLES - 1); // terminal count
	localparam logic [2:0] SAMPLE_ZERO = 3'h0;                 // counter restart

	// ==========================================================
	// alternate function pin positions
	localparam int PIN_DS_A  = 0;                              // downstream a reset out
	localparam int PIN_DS_B  = 9;                              // downstream b reset out
	localparam int PIN_DS_C  = 1;                              // downstream c reset out
	localparam int PIN_DS_D  = 10;                             // downstream d reset out
	localparam int PIN_IRQ_A = 2;                              // expander a interrupt in
	localparam int PIN_IRQ_B = 3;                              // expander b interrupt in
	localparam int PIN_IRQ_C = 4;                              // expander c interrupt in
	localparam int PIN_EVENT = 7;                              // general event out

endpackage

/* verilog/pin_sample_if.sv */
// carries synchronised pin levels and the sample strobe between modules
`timescale 1ns/1ps

interface pin_sample_if;
	logic [10:0] level;      // synchronised pin levels
	logic        sampleTick; // one-cycle strobe, spaced by the sample period

	// ==========================================================
	// sampler drives, port logic reads
	modport producer
	(
		output level,
		output sampleTick
	);
	modport consumer
	(
		input level,
		input sampleTick
	);
endinterface

/* verilog/pin_sampler.sv */
// two-stage synchroniser and sample strobe for the pin inputs
`timescale 1ns/1ps

module pin_sampler
(
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic [10:0] pinIn,
	pin_sample_if.producer   samp
);

	logic [10:0] syncFirst;        // first stage, read only by second stage
	logic [10:0] syncSecond;       // second stage, safe to use
	logic [2:0]  sampleCnt;        // sample period counter
	logic        tick;             // sample strobe register
	logic [2:0]  next_sampleCnt;   // next counter value
	logic        next_tick;        // next strobe value

	// ==========================================================
	// synchroniser: asynchronous pins into the core clock
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			syncFirst  <= gpio_pkg::LEVEL_IDLE;
			syncSecond <= gpio_pkg::LEVEL_IDLE;
		end
		else
		begin
			syncFirst  <= pinIn;      // [R15]
			syncSecond <= syncFirst;  // [R15]
		end
	end

	// ==========================================================
	// sample period counter next state
	always_comb
	begin
		next_sampleCnt = sampleCnt + 3'h1;
		next_tick      = 1'b0;
		if (sampleCnt == gpio_pkg::SAMPLE_LAST)
		begin
			// one strobe per period, never closer than the least time
			next_sampleCnt = gpio_pkg::SAMPLE_ZERO; // [R8]
			next_tick      = 1'b1;                  // [R8]
		end
	end

	// counter registers
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sampleCnt <= gpio_pkg::SAMPLE_ZERO;
			tick      <= 1'b0;
		end
		else
		begin
			sampleCnt <= next_sampleCnt;
			tick      <= next_tick;
		end
	end

	assign samp.level      = syncSecond;
	assign samp.sampleTick = tick;

endmodule

/* verilog/switch_gpio_port.sv */
// eleven-pin general purpose port with shared alternate functions
// How it works
// R1 - eleven pins, each input, output or alternate
// R2 - one select, direction, data bit per pin
// R3 - select high means alternate, direction ignored
// R4 - pins 0,9,1,10 drive downstream resets
// R5 - pins 2,3,4 receive expander interrupts
// R6 - pin 7 drives general event output
// R7 - reset clears select and direction: inputs
// R8 - inputs sampled no faster than 128ns
// R9 - unused alternate function held inactive
// R10 - general input level captured into data
// R11 - data readback shows real pin level
// R12 - general output drives data bit value
// R13 - board treats outputs as asynchronous
// R14 - registers belong to upstream configuration space
// R15 - inputs pass two-stage synchroniser first
`timescale 1ns/1ps

module switch_gpio_port
(
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic [10:0] pinIn,
	output logic      [10:0] pinOut,
	output logic      [10:0] pinOe,
	input  wire logic [10:0] cfgWrData,
	input  wire logic        functionSelectWr,
	input  wire logic        directionConfigWr,
	input  wire logic        dataWr,
	output logic      [10:0] pinFunctionSelect,
	output logic      [10:0] pinDirectionConfig,
	output logic      [10:0] pinData,
	output logic      [10:0] pinDataDrive,
	input  wire logic [3:0]  downstreamResetSrc_n,
	input  wire logic        generalEventSrc,
	output logic             downstream_a_reset_n,
	output logic             downstream_b_reset_n,
	output logic             downstream_c_reset_n,
	output logic             downstream_d_reset_n,
	output logic             expander_irq_n_a,
	output logic             expander_irq_n_b,
	output logic             expander_irq_n_c,
	output logic             general_event_out
);

	pin_sample_if samp ();                    // sampler to port logic

	logic [10:0] funcSel;                     // select bits
	logic [10:0] dirCfg;                      // direction bits
	logic [10:0] dataBits;                    // data bits
	logic [10:0] readLevel;                   // actual pin levels
	logic [10:0] next_funcSel;                // next select
	logic [10:0] next_dirCfg;                 // next direction
	logic [10:0] next_dataBits;               // next data
	logic [10:0] next_readLevel;              // next readback
	logic [10:0] next_pinOut;                 // next pin drive value
	logic [10:0] next_pinOe;                  // next pin enable
	logic [3:0]  dsReset_n;                   // downstream reset outputs
	logic [3:0]  next_dsReset_n;              // next downstream resets
	logic [2:0]  irq_n;                       // expander interrupts to core
	logic [2:0]  next_irq_n;                  // next expander interrupts
	logic        eventOut;                    // event output to core view
	logic        next_eventOut;               // next event output
	logic [10:0] gpioIn;                      // pins acting as general inputs

	// ==========================================================
	// input synchroniser and sample strobe
	pin_sampler u_sampler
	(
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.pinIn    (pinIn),
		.samp     (samp)
	);

	// ==========================================================
	// configuration and data next values
	always_comb
	begin
		gpioIn        = ~funcSel & ~dirCfg;               // [R3]
		next_funcSel  = funcSel;
		next_dirCfg   = dirCfg;
		next_dataBits = dataBits;
		// software writes land on whole registers, bit i for pin i
		if (functionSelectWr)
		begin
			next_funcSel = cfgWrData;                     // [R2] [R14]
		end
		if (directionConfigWr)
		begin
			next_dirCfg = cfgWrData;                      // [R2] [R14]
		end
		if (dataWr)
		begin
			next_dataBits = cfgWrData;                    // [R2]
		end
		// general input pins take their sampled level, over a write
		if (samp.sampleTick)
		begin
			next_dataBits = (next_dataBits & ~gpioIn) | (samp.level & gpioIn); // [R10] [R8]
		end
		// readback follows the pin whatever its mode
		next_readLevel = samp.level;                      // [R11]
	end

	// configuration registers; reset makes every pin an input
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			funcSel   <= gpio_pkg::CFG_RESET;             // [R7]
			dirCfg    <= gpio_pkg::CFG_RESET;             // [R7]
			dataBits  <= gpio_pkg::DATA_RESET;
			readLevel <= gpio_pkg::LEVEL_IDLE;
		end
		else
		begin
			funcSel   <= next_funcSel;
			dirCfg    <= next_dirCfg;
			dataBits  <= next_dataBits;
			readLevel <= next_readLevel;
		end
	end

	// ==========================================================
	// pin drive and alternate function next values
	always_comb
	begin
		// general mode: output pins drive their data bit
		next_pinOut = dataBits;                           // [R12]
		next_pinOe  = ~funcSel & dirCfg;                  // [R1] [R3]
		// alternate outputs take over drive; pins with no output stay off
		next_pinOut[gpio_pkg::PIN_DS_A] = funcSel[gpio_pkg::PIN_DS_A] ?
			downstreamResetSrc_n[0] : dataBits[gpio_pkg::PIN_DS_A];   // [R4]
		next_pinOut[gpio_pkg::PIN_DS_B] = funcSel[gpio_pkg::PIN_DS_B] ?
			downstreamResetSrc_n[1] : dataBits[gpio_pkg::PIN_DS_B];   // [R4]
		next_pinOut[gpio_pkg::PIN_DS_C] = funcSel[gpio_pkg::PIN_DS_C] ?
			downstreamResetSrc_n[2] : dataBits[gpio_pkg::PIN_DS_C];   // [R4]
		next_pinOut[gpio_pkg::PIN_DS_D] = funcSel[gpio_pkg::PIN_DS_D] ?
			downstreamResetSrc_n[3] : dataBits[gpio_pkg::PIN_DS_D];   // [R4]
		next_pinOut[gpio_pkg::PIN_EVENT] = funcSel[gpio_pkg::PIN_EVENT] ?
			generalEventSrc : dataBits[gpio_pkg::PIN_EVENT];          // [R6]
		next_pinOe[gpio_pkg::PIN_DS_A]  = dirCfg[gpio_pkg::PIN_DS_A]
			| funcSel[gpio_pkg::PIN_DS_A];                            // [R4] [R3]
		next_pinOe[gpio_pkg::PIN_DS_B]  = dirCfg[gpio_pkg::PIN_DS_B]
			| funcSel[gpio_pkg::PIN_DS_B];                            // [R4] [R3]
		next_pinOe[gpio_pkg::PIN_DS_C]  = dirCfg[gpio_pkg::PIN_DS_C]
			| funcSel[gpio_pkg::PIN_DS_C];                            // [R4] [R3]
		next_pinOe[gpio_pkg::PIN_DS_D]  = dirCfg[gpio_pkg::PIN_DS_D]
			| funcSel[gpio_pkg::PIN_DS_D];                            // [R4] [R3]
		next_pinOe[gpio_pkg::PIN_EVENT] = dirCfg[gpio_pkg::PIN_EVENT]
			| funcSel[gpio_pkg::PIN_EVENT];                           // [R6] [R3]

		// core view of alternate outputs: inactive unless pin selected
		next_dsReset_n = gpio_pkg::DS_RESET_IDLE;
		if (funcSel[gpio_pkg::PIN_DS_A])
		begin
			next_dsReset_n[0] = downstreamResetSrc_n[0];  // [R9]
		end
		if (funcSel[gpio_pkg::PIN_DS_B])
		begin
			next_dsReset_n[1] = downstreamResetSrc_n[1];  // [R9]
		end
		if (funcSel[gpio_pkg::PIN_DS_C])
		begin
			next_dsReset_n[2] = downstreamResetSrc_n[2];  // [R9]
		end
		if (funcSel[gpio_pkg::PIN_DS_D])
		begin
			next_dsReset_n[3] = downstreamResetSrc_n[3];  // [R9]
		end
		next_eventOut = funcSel[gpio_pkg::PIN_EVENT] & generalEventSrc; // [R9] [R6]

		// expander interrupts read from the pin only in alternate mode
		next_irq_n = gpio_pkg::IRQ_IDLE;                  // [R9]
		if (funcSel[gpio_pkg::PIN_IRQ_A])
		begin
			next_irq_n[0] = samp.level[gpio_pkg::PIN_IRQ_A]; // [R5]
		end
		if (funcSel[gpio_pkg::PIN_IRQ_B])
		begin
			next_irq_n[1] = samp.level[gpio_pkg::PIN_IRQ_B]; // [R5]
		end
		if (funcSel[gpio_pkg::PIN_IRQ_C])
		begin
			next_irq_n[2] = samp.level[gpio_pkg::PIN_IRQ_C]; // [R5]
		end
	end

	// pin and alternate registers; all pins released at reset
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pinOut    <= gpio_pkg::DATA_RESET;
			pinOe     <= gpio_pkg::CFG_RESET;             // [R7]
			dsReset_n <= gpio_pkg::DS_RESET_IDLE;
			irq_n     <= gpio_pkg::IRQ_IDLE;
			eventOut  <= 1'b0;
		end
		else
		begin
			pinOut    <= next_pinOut;
			pinOe     <= next_pinOe;
			dsReset_n <= next_dsReset_n;
			irq_n     <= next_irq_n;
			eventOut  <= next_eventOut;
		end
	end

	// ==========================================================
	// outputs, all straight from registers
	assign pinFunctionSelect    = funcSel;
	assign pinDirectionConfig   = dirCfg;
	assign pinData              = readLevel;
	assign pinDataDrive         = dataBits;
	assign downstream_a_reset_n = dsReset_n[0];
	assign downstream_b_reset_n = dsReset_n[1];
	assign downstream_c_reset_n = dsReset_n[2];
	assign downstream_d_reset_n = dsReset_n[3];
	assign expander_irq_n_a     = irq_n[0];
	assign expander_irq_n_b     = irq_n[1];
	assign expander_irq_n_c     = irq_n[2];
	assign general_event_out    = eventOut;

endmodule

/* bench/switch_gpio_port_monitor.sv */
// concurrent checks on the ports of the pin port
`timescale 1ns/1ps

module switch_gpio_port_monitor
(
	input wire logic        core_clk,
	input wire logic        rst_b,
	input wire logic [10:0] pinIn,
	input wire logic [10:0] pinOut,
	input wire logic [10:0] pinOe,
	input wire logic [10:0] cfgWrData,
	input wire logic        functionSelectWr,
	input wire logic        directionConfigWr,
	input wire logic [10:0] pinFunctionSelect,
	input wire logic [10:0] pinDirectionConfig,
	input wire logic [10:0] pinData,
	input wire logic [10:0] pinDataDrive,
	input wire logic [3:0]  downstreamResetSrc_n,
	input wire logic        generalEventSrc,
	input wire logic        downstream_a_reset_n,
	input wire logic        downstream_b_reset_n,
	input wire logic        downstream_c_reset_n,
	input wire logic        downstream_d_reset_n,
	input wire logic        expander_irq_n_a,
	input wire logic        expander_irq_n_b,
	input wire logic        expander_irq_n_c,
	input wire logic        general_event_out
);
	// ==========================================================
	// helpers: pins that own an output function, grouped views
	localparam logic [10:0] ALT_OUT = 11'h683;  // pins 0,1,7,9,10
	wire logic [10:0] sel    = pinFunctionSelect; // select alias
	wire logic [3:0]  dsSel  = {sel[10], sel[1], sel[9], sel[0]}; // reset pins d..a
	wire logic [3:0]  dsPin  = {pinOut[10], pinOut[1], pinOut[9], pinOut[0]};
	wire logic [3:0]  dsCore = {downstream_d_reset_n, downstream_c_reset_n,
		downstream_b_reset_n, downstream_a_reset_n};
	wire logic [2:0]  irqCore = {expander_irq_n_c, expander_irq_n_b, expander_irq_n_a};

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	// ==========================================================
	// configuration
	property p_resetCfg;
		$rose(rst_b) |-> (sel == 11'h000) && (pinDirectionConfig == 11'h000) && (pinOe == 11'h000);
	endproperty
	a_resetCfg: assert property (p_resetCfg) else $error("config not cleared by reset");
	property p_selWrite;
		functionSelectWr |=> sel == $past(cfgWrData);
	endproperty
	a_selWrite: assert property (p_selWrite) else $error("select write lost");
	property p_dirWrite;
		directionConfigWr |=> pinDirectionConfig == $past(cfgWrData);
	endproperty
	a_dirWrite: assert property (p_dirWrite) else $error("direction write lost");

	// ==========================================================
	// pin drivers
	property p_drivers;
		##1 pinOe == $past((~sel & pinDirectionConfig) | (ALT_OUT & sel));
	endproperty
	a_drivers: assert property (p_drivers) else $error("drive enable wrong");
	property p_outValue;
		##1 ((pinOut ^ $past(pinDataDrive)) & $past(~sel & pinDirectionConfig)) == 11'h000;
	endproperty
	a_outValue: assert property (p_outValue) else $error("output value wrong");
	property p_resetPins;
		##1 ((dsPin ^ $past(downstreamResetSrc_n)) & $past(dsSel)) == 4'h0;
	endproperty
	a_resetPins: assert property (p_resetPins) else $error("reset pin wrong");
	property p_eventPin;
		$past(sel[7]) |-> pinOut[7] == $past(generalEventSrc);
	endproperty
	a_eventPin: assert property (p_eventPin) else $error("event pin wrong");

	// ==========================================================
	// inputs and unused functions
	property p_readback;
		$past(rst_b, 3) |-> pinData == $past(pinIn, 3);
	endproperty
	a_readback: assert property (p_readback) else $error("readback wrong");
	property p_irqIn;
		$past(rst_b, 3) |-> (irqCore | ~$past(sel[4:2])) == ($past(pinIn[4:2], 3) | ~$past(sel[4:2]));
	endproperty
	a_irqIn: assert property (p_irqIn) else $error("expander interrupt wrong");
	property p_idleAlt;
		##1 (&(dsCore | $past(dsSel))) && (&(irqCore | $past(sel[4:2])))
			&& !(general_event_out && !$past(sel[7]));
	endproperty
	a_idleAlt: assert property (p_idleAlt) else $error("unused function active");
endmodule

bind switch_gpio_port switch_gpio_port_monitor u_switch_gpio_port_monitor (.*);

/* bench/pin_board.sv */
// board side of the pins: follows driven pins, drives the rest
`timescale 1ns/1ps

module pin_board
(
	input  wire logic [10:0] pinOut,
	input  wire logic [10:0] pinOe,
	input  wire logic [10:0] boardDrive,
	output logic      [10:0] pinLevel
);
	// ==========================================================
	// wire level with no clock: the port wins where it drives
	assign pinLevel = (pinOe & pinOut) | (~pinOe & boardDrive);
endmodule

/* bench/tb.sv */
// self-checking bench for the pin port
`timescale 1ns/1ps

module tb;
	logic        core_clk, rst_b, functionSelectWr, directionConfigWr, dataWr, generalEventSrc;
	logic [10:0] pinIn, pinOut, pinOe, cfgWrData, boardDrive;
	logic [10:0] pinFunctionSelect, pinDirectionConfig, pinData, pinDataDrive;
	logic [3:0]  downstreamResetSrc_n;
	logic        dsA, dsB, dsC, dsD, irqA, irqB, irqC, eventOut;
	wire  [10:0] altView = {3'h0, eventOut, irqC, irqB, irqA, dsD, dsC, dsB, dsA};
	int          fails, compares, n;

	switch_gpio_port u_switch_gpio_port (.core_clk(core_clk), .rst_b(rst_b), .pinIn(pinIn),
		.pinOut(pinOut), .pinOe(pinOe), .cfgWrData(cfgWrData),
		.functionSelectWr(functionSelectWr), .directionConfigWr(directionConfigWr),
		.dataWr(dataWr), .pinFunctionSelect(pinFunctionSelect),
		.pinDirectionConfig(pinDirectionConfig), .pinData(pinData), .pinDataDrive(pinDataDrive),
		.downstreamResetSrc_n(downstreamResetSrc_n), .generalEventSrc(generalEventSrc),
		.downstream_a_reset_n(dsA), .downstream_b_reset_n(dsB), .downstream_c_reset_n(dsC),
		.downstream_d_reset_n(dsD), .expander_irq_n_a(irqA), .expander_irq_n_b(irqB),
		.expander_irq_n_c(irqC), .general_event_out(eventOut));
	pin_board u_pin_board (.pinOut(pinOut), .pinOe(pinOe), .boardDrive(boardDrive),
		.pinLevel(pinIn));

	// ==========================================================
	// clock, waits, register writes, compare and closing
	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	task automatic tick(input int k);
		repeat (k) @(posedge core_clk);
		#2;
	endtask
	// kind 0 select, 1 direction, 2 data; strobe stands one edge
	task automatic wr(input int kind, input logic [10:0] v);
		cfgWrData = v;
		functionSelectWr = (kind == 0);
		directionConfigWr = (kind == 1);
		dataWr = (kind == 2);
		tick(1);
		{functionSelectWr, directionConfigWr, dataWr} = 3'h0;
		tick(1);
	endtask
	task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string what);
		compares++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic test_done;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ==========================================================
	// watchdog: the tests need some 90 cycles
	initial
	begin
		#(20 * 2000);
		fails++;
		$display("wrong value at %0t: run hung", $time);
		test_done();
	end

	// ==========================================================
	// test sequence
	initial
	begin
		rst_b = 1'b0;
		{functionSelectWr, directionConfigWr, dataWr, generalEventSrc} = 4'h0;
		cfgWrData = 11'h000;
		boardDrive = 11'h5a5;
		downstreamResetSrc_n = 4'hf;
		tick(20);
		rst_b = 1'b1;
		chk(pinFunctionSelect, 11'h000, "select");
		chk(pinDirectionConfig, 11'h000, "direction");
		chk(pinOe, 11'h000, "enables");
		chk(altView, 11'h07f, "functions idle");
		$display("reset test done");
		tick(20);
		chk(pinData, 11'h5a5, "input readback");
		chk(pinDataDrive, 11'h5a5, "input capture");
		boardDrive = 11'h2aa;
		tick(2);
		chk(pinDataDrive, 11'h5a5, "capture before sync");
		for (n = 0; n < 9 && pinDataDrive !== 11'h2aa; n++)
			tick(1);
		chk(pinDataDrive, 11'h2aa, "second capture");
		boardDrive = 11'h155;
		for (n = 0; n < 12 && pinDataDrive !== 11'h155; n++)
			tick(1);
		chk(11'(n), 11'h007, "sample spacing");
		$display("input test done");
		wr(2, 11'h143);
		wr(1, 11'h7ff);
		tick(6);
		chk(pinOe, 11'h7ff, "output enables");
		chk(pinOut, 11'h143, "output values");
		chk(pinData, 11'h143, "output readback");
		tick(8);
		chk(pinDataDrive, 11'h143, "output data kept");
		$display("output test done");
		downstreamResetSrc_n = 4'ha;
		generalEventSrc = 1'b1;
		boardDrive = 11'h014;
		wr(0, 11'h7ff);
		tick(6);
		chk(pinOe, 11'h683, "alternate enables");
		chk(pinOut & 11'h683, 11'h680, "alternate drive");
		chk(altView, 11'h0da, "alternate functions");
		chk(pinData, 11'h694, "alternate readback");
		// event pin and core view must follow the source, not stick high
		generalEventSrc = 1'b0;
		tick(2);
		chk(pinOut & 11'h683, 11'h600, "event drive follows");
		chk(altView, 11'h05a, "event view follows");
		generalEventSrc = 1'b1;
		$display("alternate test done");
		wr(0, 11'h000);
		tick(4);
		chk(altView, 11'h07f, "functions held idle");
		chk(pinOe, 11'h7ff, "back to outputs");
		$display("return test done");
		test_done();
	end
endmodule
